// ==== include/phy_bmc_regs.svh ====
`ifndef PHY_BMC_REGS_SVH
`define PHY_BMC_REGS_SVH

`define BMC_ADDR_W        5
`define BMC_DATA_W        16
`define BMC_ADDR          5'h00
`define BMC_READ_IDLE     16'h0000
`define BMC_WRITE_MASK    16'hffa0

`define BMC_BIT_RESET     15
`define BMC_BIT_LOOPBACK  14
`define BMC_BIT_SPEED     13
`define BMC_BIT_AN_EN     12
`define BMC_BIT_PDOWN     11
`define BMC_BIT_ISOLATE   10
`define BMC_BIT_RESTART   9
`define BMC_BIT_DUPLEX    8
`define BMC_BIT_COLTEST   7
`define BMC_BIT_UNIDIR    5

`define PIN_COUNT         6
`define PIN_SPEED         0
`define PIN_AUTONEG       1
`define PIN_DUPLEX        2
`define PIN_FIBRE         3
`define PIN_PDOWN_N       4
`define PIN_LINK          5
`define PIN_RESET         6'h10

`define BMC_CLK_NS        10
`define BMC_LB_DEAD_US    500
`define BMC_SWRST_CYCLES  16

`endif

// ==== include/phy_bmc_pkg.sv ====
package phy_bmc_pkg;

    typedef struct packed {
        logic       reset;
        logic       loopback;
        logic       speed_100;
        logic       an_enable;
        logic       power_down;
        logic       isolate;
        logic       an_restart;
        logic       full_duplex;
        logic       col_test;
        logic       rsvd6;
        logic       unidir;
        logic [4:0] rsvd4_0;
    } bmc_ctrl_s;

    typedef struct packed {
        logic [3:0] txd;
        logic       tx_en;
    } mii_tx_s;

    typedef struct packed {
        logic [3:0] rxd;
        logic       rx_dv;
        logic       col;
    } mii_rx_s;

    typedef enum logic [1:0] {
        SR_HOLD = 2'b00,
        SR_LOAD = 2'b01,
        SR_RUN  = 2'b11
    } sreset_e;

endpackage

// ==== logic/phy_basic_mode_control.sv ====
// Design decision made here: the strobed register port.
`timescale 1ns/1ns
`include "phy_bmc_regs.svh"
// Overview of operation
// - Reset bit starts reset, self-clears when done
// - Reset completion reloads configuration from straps
// - Loopback routes MII transmit onto receive
// - Receive data blanked during loopback dead time
// - Speed bit selects 100 or 10 manually
// - Auto-negotiation enable overrides speed and duplex bits
// - Fibre mode resets auto-negotiation enable low
// - Power-down stops transceiver, registers stay alive
// - Power-down is bit OR pin; pin sets bit
// - Isolate disconnects MII, management keeps working
// - Restart bit self-clears once negotiation starts
// - Restart ignored while auto-negotiation disabled
// - Writing restart zero leaves negotiation running
// - Duplex bit selects full or half manually
// - Collision test raises collision after transmit enable
// - Collision test drops collision after transmit enable
// - Unidirectional bit lets 100M transmit without link
// - Unidirectional bit has no effect at 10M
// - Reserved bits ignore writes, read zero
// - Speed, enable, duplex reset values from straps
// - Reset bit clears when reset ends; restart bit clears when negotiation starts
module phy_basic_mode_control #(
    parameter int SWRST_CYCLES   = `BMC_SWRST_CYCLES,
    parameter int LB_DEAD_CYCLES = (`BMC_LB_DEAD_US * 1000) / `BMC_CLK_NS
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic [`BMC_ADDR_W-1:0] reg_addr,
    input  wire logic [`BMC_DATA_W-1:0] reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [`BMC_DATA_W-1:0] reg_rdata,
    input  wire logic                   strap_speed_100,
    input  wire logic                   strap_autoneg,
    input  wire logic                   strap_full_duplex,
    input  wire logic                   fibre_mode_enable,
    input  wire logic                   power_down_pin_n,
    input  wire logic                   link_up,
    input  wire logic                   an_started,
    input  wire logic                   an_speed_100,
    input  wire logic                   an_full_duplex,
    input  wire phy_bmc_pkg::mii_tx_s   mii_tx,
    input  wire phy_bmc_pkg::mii_rx_s   phy_rx,
    output phy_bmc_pkg::mii_rx_s        mii_rx,
    output logic                        mii_out_enable,
    output logic                        core_reset,
    output logic                        power_down,
    output logic                        an_enable,
    output logic                        an_restart,
    output logic                        speed_100,
    output logic                        full_duplex,
    output logic                        tx_allowed
);
    import phy_bmc_pkg::*;

    localparam int RCW = $clog2(SWRST_CYCLES + 1);
    localparam int DCW = $clog2(LB_DEAD_CYCLES + 1);
    localparam logic [RCW-1:0] RST_LAST = RCW'(SWRST_CYCLES - 1);
    localparam logic [DCW-1:0] DEAD_LOAD = DCW'(LB_DEAD_CYCLES);
    localparam int SR_MAX = 40;

    // Pin synchronisers: a change counts once stages two and three agree
    logic [`PIN_COUNT-1:0] pin_s1_q;
    logic [`PIN_COUNT-1:0] pin_s2_q;
    logic [`PIN_COUNT-1:0] pin_s3_q;
    logic [`PIN_COUNT-1:0] pin_q;
    logic [`PIN_COUNT-1:0] pin_raw;
    logic [`PIN_COUNT-1:0] pin_d;

    always_comb
    begin
        pin_raw = '0;
        pin_raw[`PIN_SPEED]   = strap_speed_100;
        pin_raw[`PIN_AUTONEG] = strap_autoneg;
        pin_raw[`PIN_DUPLEX]  = strap_full_duplex;
        pin_raw[`PIN_FIBRE]   = fibre_mode_enable;
        pin_raw[`PIN_PDOWN_N] = power_down_pin_n;
        pin_raw[`PIN_LINK]    = link_up;
        pin_d = (pin_s2_q & ~(pin_s2_q ^ pin_s3_q)) | (pin_q & (pin_s2_q ^ pin_s3_q));
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pin_s1_q <= `PIN_RESET;
            pin_s2_q <= `PIN_RESET;
            pin_s3_q <= `PIN_RESET;
            pin_q    <= `PIN_RESET;
        end
        else
        begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_q    <= pin_d;
        end
    end

    logic pin_pdown;
    assign pin_pdown = ~pin_q[`PIN_PDOWN_N];

    // Control register and reset sequencer
    bmc_ctrl_s        ctrl_q;
    bmc_ctrl_s        ctrl_d;
    bmc_ctrl_s        wr_word;
    sreset_e          sr_q;
    sreset_e          sr_d;
    logic [RCW-1:0]   rcnt_q;
    logic [RCW-1:0]   rcnt_d;
    logic [`BMC_DATA_W-1:0] rdata_d;
    logic             wr_hit;

    always_comb
    begin
        ctrl_d  = ctrl_q;
        sr_d    = sr_q;
        rcnt_d  = rcnt_q;
        wr_hit  = reg_wr && (reg_addr == `BMC_ADDR);
        wr_word = bmc_ctrl_s'(reg_wdata & `BMC_WRITE_MASK);
        case (sr_q)
            SR_HOLD:
            begin
                // Writes during a reset are dropped; the straps win at the end
                rcnt_d = rcnt_q + RCW'(1);
                if (rcnt_q == RST_LAST)
                begin
                    sr_d = SR_LOAD;
                end
            end
            SR_LOAD:
            begin
                ctrl_d = '0;
                ctrl_d.speed_100   = pin_q[`PIN_SPEED];
                ctrl_d.full_duplex = pin_q[`PIN_DUPLEX];
                ctrl_d.an_enable   = pin_q[`PIN_AUTONEG] & ~pin_q[`PIN_FIBRE];
                sr_d = SR_RUN;
            end
            SR_RUN:
            begin
                if (wr_hit)
                begin
                    // Whole word applied; a zero in restart keeps a pending one
                    ctrl_d = wr_word;
                    ctrl_d.an_restart = ctrl_q.an_restart | wr_word.an_restart;
                    if (wr_word.reset)
                    begin
                        sr_d   = SR_HOLD;
                        rcnt_d = '0;
                    end
                end
                else if (an_started)
                begin
                    ctrl_d.an_restart = 1'b0;
                end
            end
            default:
            begin
                sr_d = SR_HOLD;
            end
        endcase
        ctrl_d.an_restart = ctrl_d.an_restart & ctrl_d.an_enable;
        ctrl_d.reset      = (sr_d != SR_RUN);
        ctrl_d.power_down = ctrl_d.power_down | pin_pdown;
        ctrl_d.rsvd6      = 1'b0;
        ctrl_d.rsvd4_0    = '0;
        // No latched or clear-on-read fields here, so a read has no side effect
        rdata_d = `BMC_READ_IDLE;
        if (reg_rd && (reg_addr == `BMC_ADDR))
        begin
            rdata_d = ctrl_q;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_q       <= '0;
            ctrl_q.reset <= 1'b1;
            sr_q         <= SR_HOLD;
            rcnt_q       <= '0;
            reg_rdata    <= `BMC_READ_IDLE;
        end
        else
        begin
            ctrl_q    <= ctrl_d;
            sr_q      <= sr_d;
            rcnt_q    <= rcnt_d;
            reg_rdata <= rdata_d;
        end
    end

    // Datapath: loopback, collision test, isolate, power-down
    logic [DCW-1:0] dead_q;
    logic [DCW-1:0] dead_d;
    logic           lb_prev_q;
    logic           lb_fresh;
    mii_rx_s        rx_d;
    mii_rx_s        rx_src;
    logic           oe_d;
    logic           pd_eff;
    logic           blank;
    logic           spd_d;
    logic           dpx_d;
    logic           txa_d;

    always_comb
    begin
        pd_eff = ctrl_q.power_down | pin_pdown;
        // Counter loads a cycle late, so the rising cycle is blanked on its own
        lb_fresh = ctrl_q.loopback && !lb_prev_q;
        dead_d = dead_q;
        if (lb_fresh)
        begin
            dead_d = DEAD_LOAD;
        end
        else if (dead_q != '0)
        begin
            dead_d = dead_q - DCW'(1);
        end
        rx_src = phy_rx;
        if (ctrl_q.loopback)
        begin
            rx_src.rxd   = mii_tx.txd;
            rx_src.rx_dv = mii_tx.tx_en;
            rx_src.col   = 1'b0;
        end
        if ((dead_q != '0) || lb_fresh)
        begin
            // Descrambler may be out of lock; nothing valid leaves meanwhile
            rx_src.rxd   = '0;
            rx_src.rx_dv = 1'b0;
        end
        if (ctrl_q.col_test)
        begin
            rx_src.col = mii_tx.tx_en;
        end
        blank = ctrl_q.isolate | pd_eff | ctrl_q.reset;
        rx_d  = blank ? '0 : rx_src;
        oe_d  = ~ctrl_q.isolate & ~pd_eff;
        spd_d = ctrl_q.an_enable ? an_speed_100 : ctrl_q.speed_100;
        dpx_d = ctrl_q.an_enable ? an_full_duplex : ctrl_q.full_duplex;
        txa_d = ~blank & (~spd_d | ctrl_q.unidir | pin_q[`PIN_LINK]);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            dead_q         <= '0;
            lb_prev_q      <= 1'b0;
            mii_rx         <= '0;
            mii_out_enable <= 1'b0;
            core_reset     <= 1'b1;
            power_down     <= 1'b0;
            an_enable      <= 1'b0;
            an_restart     <= 1'b0;
            speed_100      <= 1'b0;
            full_duplex    <= 1'b0;
            tx_allowed     <= 1'b0;
        end
        else
        begin
            dead_q         <= dead_d;
            lb_prev_q      <= ctrl_q.loopback;
            mii_rx         <= rx_d;
            mii_out_enable <= oe_d;
            core_reset     <= ctrl_q.reset;
            power_down     <= pd_eff;
            an_enable      <= ctrl_q.an_enable;
            an_restart     <= ctrl_q.an_restart;
            speed_100      <= spd_d;
            full_duplex    <= dpx_d;
            tx_allowed     <= txa_d;
        end
    end

    reset_selfclear_a: assert property (@(posedge clk) disable iff (rst)
        (sr_q == SR_HOLD) |-> ##[1:SR_MAX] (sr_q == SR_RUN) && !ctrl_q.reset)
        else $error("software reset did not finish");

    strap_reload_a: assert property (@(posedge clk) disable iff (rst)
        (sr_q == SR_LOAD) |=> (ctrl_q.speed_100 == $past(pin_q[`PIN_SPEED]))
            && (ctrl_q.full_duplex == $past(pin_q[`PIN_DUPLEX])) && !ctrl_q.loopback)
        else $error("straps not reloaded");

    fibre_an_off_a: assert property (@(posedge clk) disable iff (rst)
        (sr_q == SR_LOAD) |=> (ctrl_q.an_enable == ($past(pin_q[`PIN_AUTONEG]) && !$past(pin_q[`PIN_FIBRE]))))
        else $error("auto-negotiation enable reload wrong");

    loop_route_a: assert property (@(posedge clk) disable iff (rst)
        ctrl_q.loopback && !lb_fresh && !blank && (dead_q == '0) |=> (mii_rx.rxd == $past(mii_tx.txd))
            && (mii_rx.rx_dv == $past(mii_tx.tx_en)))
        else $error("loopback data not routed");

    dead_time_a: assert property (@(posedge clk) disable iff (rst)
        $rose(ctrl_q.loopback) |=> !mii_rx.rx_dv [*8])
        else $error("receive valid during dead time");

    col_raise_a: assert property (@(posedge clk) disable iff (rst)
        ctrl_q.col_test && mii_tx.tx_en && !blank |=> mii_rx.col)
        else $error("collision test did not raise collision");

    col_drop_a: assert property (@(posedge clk) disable iff (rst)
        ctrl_q.col_test && !mii_tx.tx_en |=> !mii_rx.col)
        else $error("collision test did not drop collision");

    pin_sets_pd_a: assert property (@(posedge clk) disable iff (rst)
        pin_pdown |=> ctrl_q.power_down ##1 power_down)
        else $error("power-down pin not honoured");

    restart_gate_a: assert property (@(posedge clk) disable iff (rst)
        !ctrl_q.an_enable |-> !ctrl_q.an_restart)
        else $error("restart held while auto-negotiation off");

    restart_clear_a: assert property (@(posedge clk) disable iff (rst)
        ctrl_q.an_restart && an_started && !wr_hit && (sr_q == SR_RUN) |=> !ctrl_q.an_restart)
        else $error("restart did not self-clear");

    manual_speed_a: assert property (@(posedge clk) disable iff (rst)
        !ctrl_q.an_enable |=> (speed_100 == $past(ctrl_q.speed_100)) && (full_duplex == $past(ctrl_q.full_duplex)))
        else $error("manual speed or duplex not applied");

    reserved_zero_a: assert property (@(posedge clk) disable iff (rst)
        reg_rd |=> !reg_rdata[6] && (reg_rdata[4:0] == 5'h00))
        else $error("reserved bits read non-zero");

    unidir_gate_a: assert property (@(posedge clk) disable iff (rst)
        tx_allowed && speed_100 |-> $past(ctrl_q.unidir) || $past(pin_q[`PIN_LINK]))
        else $error("100M transmit allowed without link");

    isolate_blank_a: assert property (@(posedge clk) disable iff (rst)
        ctrl_q.isolate |=> !mii_out_enable && (mii_rx == '0))
        else $error("isolate did not disconnect the MII");

    pdown_blank_a: assert property (@(posedge clk) disable iff (rst)
        pd_eff |=> power_down && !mii_out_enable && (mii_rx == '0))
        else $error("power-down did not stop the MII");

    an_override_a: assert property (@(posedge clk) disable iff (rst)
        ctrl_q.an_enable |=> (speed_100 == $past(an_speed_100)) && (full_duplex == $past(an_full_duplex)))
        else $error("negotiated speed or duplex not applied");

endmodule

// ==== bench/far_end_model.sv ====
`timescale 1ns/1ns
module far_end_model #(
    parameter int AN_DELAY = 6
) (
    input  wire logic           clk,
    input  wire logic           rst,
    input  wire logic           an_restart,
    output logic                an_started,
    output logic                an_speed_100,
    output logic                an_full_duplex,
    output phy_bmc_pkg::mii_rx_s phy_rx
);
    import phy_bmc_pkg::*;
    int         wait_q;
    logic [5:0] pat_q;
    // Resolved result differs from straps so an override is visible
    assign an_speed_100 = 1'b0;
    assign an_full_duplex = 1'b1;
    // Pattern moves every cycle so stale receive data never passes
    assign phy_rx = pat_q;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wait_q <= 0;
            an_started <= 1'b0;
            pat_q <= 6'h00;
        end
        else
        begin
            pat_q <= pat_q + 6'h01;
            an_started <= an_restart && wait_q == AN_DELAY;
            wait_q <= (an_restart && wait_q < AN_DELAY) ? wait_q + 1 : 0;
        end
    end
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/1ns
module tb;
    import phy_bmc_pkg::*;
    logic        clk, rst, reg_wr, reg_rd;
    logic [4:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rd_v, w;
    logic        strap_speed_100, strap_autoneg, strap_full_duplex;
    logic        fibre_mode_enable, power_down_pin_n, link_up;
    logic        an_started, an_speed_100, an_full_duplex;
    mii_tx_s     mii_tx;
    mii_rx_s     phy_rx, mii_rx;
    logic        mii_out_enable, core_reset, power_down;
    logic        an_enable, an_restart, speed_100, full_duplex, tx_allowed;
    int          err_total = 0;
    int          cmp_count = 0;

    phy_basic_mode_control #(.SWRST_CYCLES(4), .LB_DEAD_CYCLES(16)) dut (
        .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .strap_speed_100, .strap_autoneg, .strap_full_duplex, .fibre_mode_enable,
        .power_down_pin_n, .link_up, .an_started, .an_speed_100, .an_full_duplex,
        .mii_tx, .phy_rx, .mii_rx, .mii_out_enable, .core_reset, .power_down,
        .an_enable, .an_restart, .speed_100, .full_duplex, .tx_allowed
    );

    far_end_model far (.clk, .rst, .an_restart, .an_started, .an_speed_100, .an_full_duplex, .phy_rx);

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic summarize();
        if (err_total == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [4:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        rd_v = reg_rdata;
    endtask

    task automatic rdc(input logic [4:0] a, input logic [15:0] e);
        rd(a);
        chk(rd_v, e);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Writes are dropped while the reset bit still reads one
    task automatic wait_rst();
        for (int k = 0; k < 40; k++)
        begin
            rd(5'h00);
            if (rd_v[15] === 1'b0)
                break;
        end
    endtask

    initial
    begin
        #100000;
        err_total++;
        summarize();
    end

    initial
    begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
        strap_speed_100 = 1'b1;
        strap_autoneg = 1'b1;
        strap_full_duplex = 1'b0;
        fibre_mode_enable = 1'b0;
        power_down_pin_n = 1'b1;
        link_up = 1'b0;
        mii_tx = 5'h15;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        wait_rst();
        rdc(5'h00, 16'h3000);
        chk(16'({an_enable, speed_100, full_duplex}), 16'h0005);
        rdc(5'h01, 16'h0000);
        wr(5'h01, 16'hffff);
        rdc(5'h00, 16'h3000);
        wr(5'h00, 16'h1200);
        rdc(5'h00, 16'h1200);
        chk(16'(an_restart), 16'h0001);
        tick(12);
        rdc(5'h00, 16'h1000);
        chk(16'(an_restart), 16'h0000);
        wr(5'h00, 16'h1200);
        wr(5'h00, 16'h1000);
        rdc(5'h00, 16'h1200);
        tick(12);
        wr(5'h00, 16'h0200);
        rdc(5'h00, 16'h0000);
        for (int i = 0; i < 4; i++)
        begin
            w = 16'h0000;
            w[13] = i[1];
            w[8] = i[0];
            wr(5'h00, w);
            tick(2);
            chk(16'({speed_100, full_duplex, tx_allowed}), 16'({i[1], i[0], ~i[1]}));
        end
        wr(5'h00, 16'h2020);
        tick(2);
        chk(16'(tx_allowed), 16'h0001);
        wr(5'h00, 16'h2000);
        tick(2);
        chk(16'(tx_allowed), 16'h0000);
        @(posedge clk);
        link_up <= 1'b1;
        tick(6);
        chk(16'(tx_allowed), 16'h0001);
        wr(5'h00, 16'h007f);
        rdc(5'h00, 16'h0020);
        wr(5'h00, 16'h0080);
        tick(2);
        chk(16'(mii_rx.col), 16'h0001);
        @(posedge clk);
        mii_tx <= 5'h14;
        tick(2);
        chk(16'(mii_rx.col), 16'h0000);
        @(posedge clk);
        mii_tx <= 5'h15;
        wr(5'h00, 16'h4000);
        tick(1);
        chk(16'(mii_rx), 16'h0000);
        tick(12);
        chk(16'(mii_rx), 16'h0000);
        tick(10);
        chk(16'(mii_rx), 16'h002a);
        wr(5'h00, 16'h0400);
        tick(2);
        chk(16'({mii_out_enable, mii_rx}), 16'h0000);
        rdc(5'h00, 16'h0400);
        wr(5'h00, 16'h0000);
        @(posedge clk);
        power_down_pin_n <= 1'b0;
        tick(6);
        chk(16'({power_down, mii_out_enable}), 16'h0002);
        rdc(5'h00, 16'h0800);
        @(posedge clk);
        power_down_pin_n <= 1'b1;
        tick(6);
        chk(16'(power_down), 16'h0001);
        wr(5'h00, 16'h0000);
        tick(2);
        chk(16'({power_down, mii_out_enable}), 16'h0001);
        @(posedge clk);
        fibre_mode_enable <= 1'b1;
        strap_full_duplex <= 1'b1;
        tick(6);
        wr(5'h00, 16'h8000);
        rd(5'h00);
        chk(16'({rd_v[15], core_reset}), 16'h0003);
        wait_rst();
        rdc(5'h00, 16'h2100);
        summarize();
    end
endmodule
